// ==== test/port_ingress_class_tagging_tb_top.sv ====
// self-checking bench for the per-port control block
// assumes station_model drives the request streams
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD %0t value mismatch", $time); end end
module port_ingress_class_tagging_tb_top;
  // =====================================================================
  // signals
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [3:0] split_hi = 4'h0;
  logic [3:0][1:0] queue_mode;
  logic [3:0][11:0] port_vid;
  port_ctl_pkg::ing_req_t ing_req;
  port_ctl_pkg::ing_res_t ing_res;
  port_ctl_pkg::egr_req_t egr_req;
  port_ctl_pkg::egr_res_t egr_res;
  int bad_count = 0;
  int checked = 0;
  logic [7:0] addrs [5] = '{8'h10, 8'h20, 8'h30, 8'h50, 8'h40};
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  port_ingress_class_tagging i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ing_req(ing_req), .ing_res(ing_res), .egr_req(egr_req), .port_vid(port_vid),
    .egr_res(egr_res), .split_hi(split_hi), .queue_mode(queue_mode));
  station_model i_stn (.sys_clk(sys_clk), .ing_req(ing_req), .egr_req(egr_req),
    .port_vid(port_vid), .ing_res(ing_res), .egr_res(egr_res));
  // =====================================================================
  // bus cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge sys_clk);
    #2 reg_wr = 1'b0;
  endtask
  // write, then read the same slot in the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    #2 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge sys_clk);
    #2 {reg_wr, reg_rd} = 2'b01;
    @(posedge sys_clk);
    #1 q = reg_rdata;
    #1 reg_rd = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #2 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge sys_clk);
    #1 d = reg_rdata;
    #1 reg_rd = 1'b0;
  endtask
  // cls is {ds_valid, ds_prio, up_valid, up_prio}
  task automatic ing(input logic [1:0] p, input logic b, input logic [5:0] cls,
    output port_ctl_pkg::ing_res_t a);
    i_stn.send_ing({1'b1, p, b, cls}, a);
  endtask
  function automatic port_ctl_pkg::ing_res_t ires(input logic [1:0] q, input logic s);
    return {1'b1, q, s};
  endfunction
  // =====================================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] d;
    port_ctl_pkg::ing_res_t r;
    @(posedge sys_clk);
    #2 rst_b = 1'b0;
    repeat (16) @(posedge sys_clk);
    #2 rst_b = 1'b1;
    ing(2'd0, 1'b1, 6'h3f, r);
    `CHK(r, ires(2'd0, 1'b0))
    `CHK(queue_mode, 8'h00)
    foreach (addrs[i])
    begin
      rd(addrs[i], d);
      `CHK(d, 8'h00)
    end
  endtask
  task automatic t_map;
    logic [7:0] vals [5] = '{8'ha5, 8'h5a, 8'hc3, 8'h3c, 8'hff};
    logic [7:0] d;
    foreach (addrs[i]) wr(addrs[i], vals[i]);
    foreach (addrs[i])
    begin
      rd(addrs[i], d);
      `CHK(d, (i < 4) ? vals[i] : 8'h00)
    end
    wr_rd(8'h10, 8'h96, d);
    `CHK(d, 8'h96)
  endtask
  task automatic t_class;
    logic [7:0] ctl [10] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h48, 8'h48, 8'h30, 8'h70,
      8'h70, 8'h70};
    logic [5:0] cls [10] = '{6'h3f, 6'h3f, 6'h3f, 6'h3f, 6'h35, 6'h17, 6'h3d, 6'h2e,
      6'h1c, 6'h0a};
    logic [1:0] q [10] = '{2'd0, 2'd1, 2'd2, 2'd3, 2'd2, 2'd1, 2'd1, 2'd3, 2'd0, 2'd2};
    port_ctl_pkg::ing_res_t r;
    wr(8'h20, 8'h18);
    foreach (ctl[i])
    begin
      wr(8'h30, ctl[i]);
      ing(2'd2, 1'b0, cls[i], r);
      `CHK(r, ires(q[i], 1'b0))
    end
  endtask
  task automatic t_storm;
    port_ctl_pkg::ing_res_t r;
    wr(8'h50, 8'h80);
    wr(8'h10, 8'h00);
    ing(2'd3, 1'b1, 6'h00, r);
    `CHK(r, ires(2'd0, 1'b1))
    ing(2'd3, 1'b0, 6'h00, r);
    `CHK(r, ires(2'd0, 1'b0))
    ing(2'd0, 1'b1, 6'h00, r);
    `CHK(r, ires(2'd0, 1'b0))
  endtask
  task automatic t_tag;
    logic [4:0] req [4] = '{5'h0c, 5'h0d, 5'h07, 5'h06};
    logic [14:0] exp [4] = '{15'h63c3, 15'h4000, 15'h5000, 15'h4000};
    port_ctl_pkg::egr_res_t a;
    wr(8'h20, 8'h04);
    wr(8'h10, 8'h02);
    foreach (req[i])
    begin
      i_stn.send_egr({1'b1, req[i]}, a);
      `CHK(a, exp[i])
    end
  endtask
  task automatic t_split;
    wr(8'h10, 8'h01);
    wr(8'h20, 8'h00);
    wr(8'h30, 8'h01);
    wr(8'h50, 8'h00);
    @(posedge sys_clk);
    #2 split_hi = 4'h3;
    repeat (2) @(posedge sys_clk);
    #1 `CHK(queue_mode, 8'h1b)
    #1 split_hi = 4'h0;
  endtask
  // =====================================================================
  // verdict, main sequence and watchdog
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    t_reset();
    t_map();
    t_class();
    t_storm();
    t_tag();
    t_split();
    t_reset();
    close_out();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire

// ==== test/station_model.sv ====
// ethernet station model: issues ingress and egress requests, holds port vids
// assumes the bench calls its tasks and takes answers through them
`timescale 1ns/10ps
`default_nettype none
module station_model (
  // clock
  input wire logic sys_clk,
  // requests and default vids
  output port_ctl_pkg::ing_req_t ing_req,
  output port_ctl_pkg::egr_req_t egr_req,
  output logic [3:0][11:0] port_vid,
  // answers
  input wire port_ctl_pkg::ing_res_t ing_res,
  input wire port_ctl_pkg::egr_res_t egr_res
);
  // =====================================================================
  // distinct vid per port so a wrong index shows
  assign port_vid = {12'h4d4, 12'h3c3, 12'h2b2, 12'h1a1};
  initial
  begin
    ing_req = '0;
    egr_req = '0;
  end
  // =====================================================================
  // one request per call; released lines show inverted fields
  task automatic send_ing(input port_ctl_pkg::ing_req_t r,
    output port_ctl_pkg::ing_res_t a);
    @(posedge sys_clk);
    #2 ing_req = r;
    @(posedge sys_clk);
    #1 a = ing_res;
    #1 ing_req = {1'b0, ~r[8:0]};
  endtask
  task automatic send_egr(input port_ctl_pkg::egr_req_t r,
    output port_ctl_pkg::egr_res_t a);
    @(posedge sys_clk);
    #2 egr_req = r;
    @(posedge sys_clk);
    #1 a = egr_res;
    #1 egr_req = {1'b0, ~r[4:0]};
  endtask
endmodule
`default_nettype wire

// ==== verilog/port_ctl_consts.svh ====
// offsets, field positions, reset values and widths of the per-port control registers
// assumes an eight-bit register port with byte addresses, one slot per port
//
// What this block does
// - ports 1 to 3 each have one control register, at 0x10, 0x20 and 0x30.
// - the port 4 register is at 0x50; 0x40 is reserved with no function.
// - bit 7 turns broadcast storm protection on for that port's ingress.
// - bit 6 turns DiffServ classification of ingress packets on.
// - bit 5 turns 802.1p user priority classification of ingress packets on.
// - bits 4 to 3 give the default queue when no classifier yields one.
// - with both classifiers giving a class, their OR replaces the port priority.
// - bit 2 adds an 802.1Q tag on egress to packets that arrived untagged.
// - packets that arrived tagged never get a second tag.
// - an inserted tag carries the default VID of the ingress port.
// - bit 1 strips the 802.1Q tag from tagged packets on egress.
// - with stripping on, untagged packets are not stripped.
// - bit 0 with another register's bit selects one, two or four queues.
`ifndef PORT_CTL_CONSTS_SVH
`define PORT_CTL_CONSTS_SVH

// =====================================================================
// register offsets
`define PCT_ADDR_P1 8'h10
`define PCT_ADDR_P2 8'h20
`define PCT_ADDR_P3 8'h30
`define PCT_ADDR_RSVD 8'h40
`define PCT_ADDR_P4 8'h50

// =====================================================================
// field positions
`define PCT_BIT_STORM 7
`define PCT_BIT_DIFFSERV 6
`define PCT_BIT_DOT1P 5
`define PCT_PRIO_MSB 4
`define PCT_PRIO_LSB 3
`define PCT_BIT_INSERT 2
`define PCT_BIT_REMOVE 1
`define PCT_BIT_SPLIT 0

// =====================================================================
// reset values and widths
`define PCT_CTL_RESET 8'h00
`define PCT_RDATA_IDLE 8'h00
`define PCT_VID_NONE 12'h000
`define PCT_NUM_PORTS 4
`define PCT_VID_W 12

`endif

// ==== verilog/port_ctl_pkg.sv ====
// types shared by the per-port control slots and the decision logic
// assumes port_ctl_consts.svh is available for inclusion
`default_nettype none
`include "port_ctl_consts.svh"

package port_ctl_pkg;

  // =====================================================================
  // one control register, fields from bit 7 down to bit 0
  typedef struct packed {
    logic storm_en;
    logic diffserv_en;
    logic dot1p_en;
    logic [1:0] port_prio;
    logic tag_insert;
    logic tag_remove;
    logic split_lo;
  } ctl_t;

  // =====================================================================
  // ingress classification request and answer
  typedef struct packed {
    logic valid;
    logic [1:0] port;
    logic bcast;
    logic ds_valid;
    logic [1:0] ds_prio;
    logic up_valid;
    logic [1:0] up_prio;
  } ing_req_t;

  typedef struct packed {
    logic valid;
    logic [1:0] queue;
    logic storm_check;
  } ing_res_t;

  // =====================================================================
  // egress tagging request and answer
  typedef struct packed {
    logic valid;
    logic [1:0] out_port;
    logic [1:0] in_port;
    logic arrived_tagged;
  } egr_req_t;

  typedef struct packed {
    logic valid;
    logic add_tag;
    logic strip_tag;
    logic [11:0] vid;
  } egr_res_t;

endpackage
`default_nettype wire

// ==== verilog/port_ctl_slot.sv ====
// one port's eight-bit control register
// assumes writes arrive as single-cycle strobes on the shared register port
`timescale 1ns/10ps
`default_nettype none
`include "port_ctl_consts.svh"

module port_ctl_slot #(
  parameter logic [7:0] ADDR = `PCT_ADDR_P1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register write
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // decoded fields
  output port_ctl_pkg::ctl_t ctl
);

  logic [7:0] ctl_byte;
  logic [7:0] next_ctl_byte;

  always_comb
  begin
    next_ctl_byte = ctl_byte;
    if (wr_en && (wr_addr == ADDR))
    begin
      next_ctl_byte = wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_byte <= `PCT_CTL_RESET;
    end
    else
    begin
      ctl_byte <= next_ctl_byte;
    end
  end

  assign ctl = port_ctl_pkg::ctl_t'(ctl_byte);

endmodule
`default_nettype wire

// ==== verilog/port_ingress_class_tagging.sv ====
// per-port ingress classification and egress tagging control
// assumes the forwarding engine presents one ingress and one egress request per cycle
`timescale 1ns/10ps
`default_nettype none
`include "port_ctl_consts.svh"

module port_ingress_class_tagging #(
  parameter int NUM_PORTS = `PCT_NUM_PORTS,
  parameter int VID_W = `PCT_VID_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // ingress classification
  input wire port_ctl_pkg::ing_req_t ing_req,
  output port_ctl_pkg::ing_res_t ing_res,
  // egress tagging
  input wire port_ctl_pkg::egr_req_t egr_req,
  input wire logic [NUM_PORTS-1:0][VID_W-1:0] port_vid,
  output port_ctl_pkg::egr_res_t egr_res,
  // queue split
  input wire logic [NUM_PORTS-1:0] split_hi,
  output logic [NUM_PORTS-1:0][1:0] queue_mode
);

  // =====================================================================
  // control registers, one slot per port
  localparam logic [7:0] SLOT_ADDR [4] = '{`PCT_ADDR_P1, `PCT_ADDR_P2,
                                          `PCT_ADDR_P3, `PCT_ADDR_P4};

  port_ctl_pkg::ctl_t ctl [NUM_PORTS];

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1)
    begin : gen_slot
      port_ctl_slot #(
        .ADDR(SLOT_ADDR[g])
      ) u_slot (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(reg_wr),
        .wr_addr(reg_addr),
        .wr_data(reg_wdata),
        .ctl(ctl[g])
      );
    end
  endgenerate

  // =====================================================================
  // register read
  logic [7:0] next_rdata;

  always_comb
  begin
    next_rdata = reg_rdata;
    if (reg_rd)
    begin
      // the reserved slot and any other address read zero
      next_rdata = `PCT_RDATA_IDLE;
      for (int i = 0; i < NUM_PORTS; i++)
      begin
        if (reg_addr == SLOT_ADDR[i])
        begin
          next_rdata = ctl[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= `PCT_RDATA_IDLE;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // =====================================================================
  // ingress classification
  port_ctl_pkg::ing_res_t next_ing_res;
  port_ctl_pkg::ctl_t ic;
  logic ds_ok;
  logic up_ok;

  always_comb
  begin
    ic = ctl[ing_req.port];
    ds_ok = ic.diffserv_en && ing_req.ds_valid;
    up_ok = ic.dot1p_en && ing_req.up_valid;
    next_ing_res = '0;
    next_ing_res.valid = ing_req.valid;
    if (ing_req.valid)
    begin
      next_ing_res.storm_check = ic.storm_en && ing_req.bcast;
      if (ds_ok && up_ok)
      begin
        next_ing_res.queue = ing_req.ds_prio | ing_req.up_prio;
      end
      else if (ds_ok)
      begin
        next_ing_res.queue = ing_req.ds_prio;
      end
      else if (up_ok)
      begin
        next_ing_res.queue = ing_req.up_prio;
      end
      else
      begin
        next_ing_res.queue = ic.port_prio;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ing_res <= '0;
    end
    else
    begin
      ing_res <= next_ing_res;
    end
  end

  // =====================================================================
  // egress tagging
  port_ctl_pkg::egr_res_t next_egr_res;
  port_ctl_pkg::ctl_t ec;

  always_comb
  begin
    ec = ctl[egr_req.out_port];
    next_egr_res = '0;
    next_egr_res.valid = egr_req.valid;
    if (egr_req.valid)
    begin
      // only untagged arrivals gain a tag
      next_egr_res.add_tag = ec.tag_insert && !egr_req.arrived_tagged;
      // untagged arrivals are never stripped
      next_egr_res.strip_tag = ec.tag_remove && egr_req.arrived_tagged;
      if (next_egr_res.add_tag)
      begin
        next_egr_res.vid = port_vid[egr_req.in_port];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      egr_res <= '0;
    end
    else
    begin
      egr_res <= next_egr_res;
    end
  end

  // =====================================================================
  // queue split selection
  logic [NUM_PORTS-1:0][1:0] next_queue_mode;

  always_comb
  begin
    for (int i = 0; i < NUM_PORTS; i++)
    begin
      next_queue_mode[i] = {split_hi[i], ctl[i].split_lo};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      queue_mode <= '0;
    end
    else
    begin
      queue_mode <= next_queue_mode;
    end
  end

  // =====================================================================
  // assertions
  a_read_slot1: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_wr && reg_addr == `PCT_ADDR_P1 ##1 reg_rd && reg_addr == `PCT_ADDR_P1 && !reg_wr
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("port 1 control does not read back");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    reg_rd && reg_addr == `PCT_ADDR_RSVD |=> reg_rdata == 8'h00)
    else $error("reserved slot read not zero");

  a_storm_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ing_req.valid |=> ing_res.storm_check == ($past(ic.storm_en) && $past(ing_req.bcast)))
    else $error("storm check mismatch");

  a_default_queue: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ing_req.valid && !ds_ok && !up_ok |=> ing_res.queue == $past(ic.port_prio))
    else $error("default queue not applied");

  a_or_merge: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ing_req.valid && ds_ok && up_ok
    |=> ing_res.queue == ($past(ing_req.ds_prio) | $past(ing_req.up_prio)))
    else $error("merged priority not the or");

  a_ds_only: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ing_req.valid && ds_ok && !up_ok |=> ing_res.queue == $past(ing_req.ds_prio))
    else $error("diffserv class not used");

  a_no_double_tag: assert property (@(posedge sys_clk) disable iff (!rst_b)
    egr_req.valid && egr_req.arrived_tagged |=> !egr_res.add_tag)
    else $error("tag stacked on tagged packet");

  a_insert_vid: assert property (@(posedge sys_clk) disable iff (!rst_b)
    egr_req.valid && ec.tag_insert && !egr_req.arrived_tagged
    |=> egr_res.add_tag && egr_res.vid == $past(port_vid[egr_req.in_port]))
    else $error("inserted vid not ingress default");

  a_untagged_intact: assert property (@(posedge sys_clk) disable iff (!rst_b)
    egr_req.valid && !egr_req.arrived_tagged |=> !egr_res.strip_tag)
    else $error("untagged packet modified");

  a_reset_clear: assert property (@(posedge sys_clk)
    $rose(rst_b) |-> ctl[0] == '0 && ctl[3] == '0)
    else $error("control not cleared by reset");

  c_merge: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ing_req.valid && ds_ok && up_ok);
  c_insert: cover property (@(posedge sys_clk) disable iff (!rst_b)
    egr_res.valid && egr_res.add_tag);
  c_strip: cover property (@(posedge sys_clk) disable iff (!rst_b)
    egr_res.valid && egr_res.strip_tag);

endmodule
`default_nettype wire
